// ==== logic/gdis_core.sv ====
// Gate drive init sequencer: lockout of the high-side drive on standby
// or fault, edge-driven recovery, and the command register block.
// Assumes i_clk at 10 MHz; phase, enable, release and fault pins are
// asynchronous and the host drives them as a microcontroller would.
`timescale 1ns/10ps
`include "gdis_cfg.svh"

// Summary of operation
// R01: Standby or fault forces gates low, locks high-side.
// R02: Host may shorten recovery low-side pulse.
// R03: Host clears pending interrupts before raising enables.
// R04: Low-side outputs enabled only with both enables.
// R05: Low-side pulse re-enables that phase's high-side drive.
// R06: Host pulses high-side low for dead time plus.
// R07: Host pulses all high-side inputs together.
// R08: After high-side pulse, high gate held off.
// R09: Inputs edge driven; early high-side edges ignored.
// R10: Unlock needs enables high and normal mode.
// R11: Host waits 280 ns after enables before low-side.
// R12: Host may tie phase inputs together.
// R13: Release with enables low powers up, pump optional.
// R14: Host sends both clear commands during setup.
// R15: Mask command nibble suppresses chosen interrupt sources.
// R16: Host sets dead time before enabling outputs.
// R17: Mode command with lock bit freezes mode.
// R18: Host follows six-step power-up output sequence.
// R19: Host reads status, corrects, then clears fault.
// R20: Command response returned on following transfer.
// R21: One lock flag per phase, set and cleared.
module gdis_core
  import gdis_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Avalon-MM slave.
  input  wire logic [3:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  // Device pins from the host.
  input  wire logic        i_release_n,
  input  wire logic        i_enable_one,
  input  wire logic        i_enable_two,
  input  wire gdis_cmd_t   i_cmd,
  input  wire logic        i_fault,
  // Device pins toward the power stage and the host.
  output gdis_gate_t       o_gate,
  output logic             o_pump_en,
  output logic             o_irq_req
);

  // Every assertion below runs on the one clock and is off in reset.
  default clocking gdis_cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [9:0] meta_r;
  logic [9:0] sync_r;
  logic [9:0] prev_r;
  logic       en_both;
  logic       released;
  logic       fault_s;
  gdis_cmd_t  cmd_s;
  gdis_cmd_t  cmd_p;

  // Two flops on every pin, then prev_r for edges; logic reads sync_r and prev_r. They reset to the
  // idle pin levels, so the high-side inputs, idle high, show no false edge.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= `GDIS_SYNC_RST;
      sync_r <= `GDIS_SYNC_RST;
      prev_r <= `GDIS_SYNC_RST;
    end else begin
      meta_r <= {i_release_n, i_enable_one, i_enable_two, i_fault, i_cmd};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign released = sync_r[9];
  assign en_both  = sync_r[8] & sync_r[7];
  assign fault_s  = sync_r[6];
  assign cmd_s    = sync_r[5:0];
  assign cmd_p    = prev_r[5:0];

  // ------------------------------------------------------------------
  // Operating state
  // ------------------------------------------------------------------
  gdis_state_t st_r;
  logic [1:0]  wake_cnt_r;
  logic        shut;

  // A fault or loss of either enable shuts the stage down at once.
  assign shut = ~released | ~en_both | fault_s;

  // Normal mode only after the standby exit time has elapsed. [R10]
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r       <= GDIS_STANDBY;
      wake_cnt_r <= 2'h0;
    end else begin
      unique case (st_r)
        GDIS_STANDBY: begin
          wake_cnt_r <= 2'h0;
          if (!shut) begin
            st_r <= GDIS_WAKE;
          end
        end
        GDIS_WAKE: begin
          wake_cnt_r <= wake_cnt_r + 2'h1;
          if (shut) begin
            st_r <= GDIS_STANDBY;
          end else if (wake_cnt_r == 2'(`GDIS_WAKE_CYC - 2)) begin
            st_r <= GDIS_NORMAL;
          end
        end
        GDIS_NORMAL: begin
          if (shut) begin
            st_r <= GDIS_STANDBY;
          end
        end
        default: begin
          st_r <= GDIS_STANDBY;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Per-phase lockout and gate drive
  // ------------------------------------------------------------------
  logic [2:0] lock_r;
  logic [2:0] hs_on_r;
  logic [2:0] ls_rise;
  logic [2:0] hs_fall;
  logic [2:0] hs_rise;
  logic       normal;

  assign normal  = (st_r == GDIS_NORMAL) & ~shut;
  assign ls_rise = cmd_s.low_side_cmd_in & ~cmd_p.low_side_cmd_in;
  assign hs_fall = ~cmd_s.high_side_cmd_n_in & cmd_p.high_side_cmd_n_in;
  assign hs_rise = cmd_s.high_side_cmd_n_in & ~cmd_p.high_side_cmd_n_in;

  // Lock is set while not in normal mode and cleared by a qualified
  // low-side rising edge. [R01] [R05] [R10] [R21]
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lock_r <= `GDIS_LOCK_ALL;
    end else if (!normal) begin
      lock_r <= `GDIS_LOCK_ALL;
    end else begin
      lock_r <= lock_r & ~ls_rise;
    end
  end

  // High-side state follows input edges only while unlocked; an edge
  // seen while locked is dropped, so the gate stays off. [R09] [R08]
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hs_on_r <= 3'h0;
    end else if (!normal) begin
      hs_on_r <= 3'h0;
    end else begin
      hs_on_r <= (hs_on_r | (hs_fall & ~lock_r)) & ~hs_rise & ~lock_r;
    end
  end

  // Registered gate outputs; low side needs normal mode. [R04] [R01]
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_gate <= '0;
    end else if (!normal) begin
      o_gate <= '0;
    end else begin
      o_gate.low_gate      <= cmd_s.low_side_cmd_in;
      o_gate.high_gate_out <= hs_on_r & ~lock_r & ~cmd_s.low_side_cmd_in;
    end
  end

  // ------------------------------------------------------------------
  // Command register block
  // ------------------------------------------------------------------
  logic       ack_r;
  logic       wr_acc;
  logic       cmd_wr;
  logic [3:0] op;
  logic [3:0] arg;
  logic [3:0] mask_r;
  logic [2:0] mode_r;
  logic       mode_locked_r;
  logic [3:0] dead_r;
  logic [3:0] stat_r;
  logic [3:0] stat_set;
  logic [3:0] stat_clr;
  logic [7:0] resp_r;
  logic [7:0] word_one;
  logic [7:0] word_two;
  logic       was_normal_r;

  // Every access waits one cycle, then completes.
  assign o_waitrequest = (i_read | i_write) & ~ack_r;
  assign wr_acc        = i_write & ack_r;
  assign cmd_wr        = wr_acc & (i_address == `GDIS_OFS_CMD);
  assign op            = i_writedata[7:4];
  assign arg           = i_writedata[3:0];
  assign word_one      = {1'b0, lock_r, stat_r};
  assign word_two      = {mode_locked_r, mode_r, mask_r};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (i_read | i_write) & ~ack_r;
    end
  end

  // Mask load from opcode 0010 or 0011. [R15]
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_r <= `GDIS_MASK_RST;
    end else if (cmd_wr && (op == `GDIS_OP_MASK_LO || op == `GDIS_OP_MASK_HI)) begin
      mask_r <= arg;
    end
  end

  // Mode bits apply on each mode command until the lock bit is written; it freezes them. [R17]
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_r        <= `GDIS_MODE_RST;
      mode_locked_r <= 1'b0;
    end else if (cmd_wr && op == `GDIS_OP_MODE && !mode_locked_r) begin
      mode_r        <= arg[3:1];
      mode_locked_r <= arg[`GDIS_MODE_LOCK_BIT];
    end
  end

  // Dead time setting is held and shown on the live register.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dead_r <= 4'h0;
    end else if (cmd_wr && op == `GDIS_OP_DEADTIME) begin
      dead_r <= arg;
    end
  end

  // Sticky status: fault, shutdown, blocked edge, rejected mode.
  assign stat_set = {cmd_wr & (op == `GDIS_OP_MODE) & mode_locked_r,
                     |(hs_fall & lock_r) & normal,
                     was_normal_r & ~normal,
                     fault_s};
  assign stat_clr = {{2{cmd_wr & (op == `GDIS_OP_CLR_B)}},
                     {2{cmd_wr & (op == `GDIS_OP_CLR_A)}}};

  // A set in the clearing cycle wins over the clear, so no event is lost;
  // the one-cycle history of normal mode that marks a shutdown lives here too.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stat_r       <= 4'h0;
      was_normal_r <= 1'b0;
    end else begin
      stat_r       <= (stat_r & ~stat_clr) | stat_set;
      was_normal_r <= normal;
    end
  end

  // Masked sources never reach the request pin. [R15]
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq_req <= 1'b0;
    end else begin
      o_irq_req <= |(stat_r & ~mask_r);
    end
  end

  // Pump runs after release when configured, enables still low. [R13]
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pump_en <= 1'b0;
    end else begin
      o_pump_en <= released & mode_r[`GDIS_MODE_PUMP_BIT - 1];
    end
  end

  // The answer to a command is read on the next transfer. [R20]
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      resp_r <= 8'h00;
    end else if (cmd_wr) begin
      resp_r <= (op == `GDIS_OP_READ_B) ? word_two : word_one;
    end
  end

  // Read data is loaded in the wait cycle so it stands at acceptance.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_readdata <= 32'h0000_0000;
    end else if (i_read && !ack_r) begin
      unique case (i_address)
        `GDIS_OFS_RESP: o_readdata <= {24'h00_0000, resp_r};
        `GDIS_OFS_LIVE: o_readdata <= {16'h0000, dead_r, st_r, 2'h0, word_one};
        default:        o_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  property p_shut_low;
    !normal |=> (o_gate == '0) && (lock_r == `GDIS_LOCK_ALL);
  endproperty
  a_shut_low: assert property (p_shut_low) else $error("gates not forced off"); // [R01]
  property p_low_needs_en;
    (o_gate.low_gate != 3'h0) |-> $past(en_both) && $past(st_r == GDIS_NORMAL);
  endproperty
  a_low_needs_en: assert property (p_low_needs_en) else $error("low side without enables"); // [R04]
  property p_unlock_cause;
    $fell(lock_r[0]) |-> $past(ls_rise[0] && normal);
  endproperty
  a_unlock_cause: assert property (p_unlock_cause) else $error("unlock without low pulse"); // [R05]
  property p_unlock_done;
    (ls_rise[1] && normal) ##1 normal |-> !lock_r[1];
  endproperty
  a_unlock_done: assert property (p_unlock_done) else $error("low pulse did not unlock"); // [R21]
  property p_locked_edge;
    lock_r[2] && hs_fall[2] |=> ##1 !o_gate.high_gate_out[2];
  endproperty
  a_locked_edge: assert property (p_locked_edge) else $error("locked edge drove gate"); // [R09]
  property p_hs_off;
    hs_rise[0] |=> ##1 !o_gate.high_gate_out[0];
  endproperty
  a_hs_off: assert property (p_hs_off) else $error("high gate not off after pulse"); // [R08]
  property p_wake_time;
    (st_r == GDIS_STANDBY) && !shut |=> (st_r != GDIS_NORMAL) [*2];
  endproperty
  a_wake_time: assert property (p_wake_time) else $error("normal before wake time"); // [R10]
  property p_mode_frozen;
    mode_locked_r |=> $stable(mode_r) && mode_locked_r;
  endproperty
  a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed after lock"); // [R17]
  property p_mask_gate;
    ((stat_r & ~mask_r) == 4'h0) |=> !o_irq_req;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("masked source raised request"); // [R15]
  property p_resp_next;
    cmd_wr && (op == `GDIS_OP_READ_B) |=> resp_r == $past(word_two);
  endproperty
  a_resp_next: assert property (p_resp_next) else $error("response not held for next"); // [R20]
  property p_pump;
    !released |=> !o_pump_en;
  endproperty
  a_pump: assert property (p_pump) else $error("pump on before release"); // [R13]

  c_normal:  cover property ($rose(normal));
  c_unlock:  cover property ($fell(lock_r[0]));
  c_hs_on:   cover property ($rose(o_gate.high_gate_out[0]));
  c_lock_md: cover property ($rose(mode_locked_r));

endmodule

// ==== logic/gdis_cfg.svh ====
// Constants of the gate drive init sequencer: offsets, opcodes, timing.
// Assumes inclusion by the package and by the core module only.
`ifndef GDIS_CFG_SVH
`define GDIS_CFG_SVH
// Register byte offsets on the Avalon-MM slave.
`define GDIS_OFS_CMD       4'h0
`define GDIS_OFS_RESP      4'h4
`define GDIS_OFS_LIVE      4'h8
// Command opcodes in the upper nibble of the command byte.
`define GDIS_OP_READ_A     4'h0
`define GDIS_OP_READ_B     4'h1
`define GDIS_OP_MASK_LO    4'h2
`define GDIS_OP_MASK_HI    4'h3
`define GDIS_OP_MODE       4'h4
`define GDIS_OP_CLR_A      4'h6
`define GDIS_OP_CLR_B      4'h7
`define GDIS_OP_DEADTIME   4'h8
// Field positions and reset values.
`define GDIS_MODE_LOCK_BIT 0
`define GDIS_MODE_PUMP_BIT 1
`define GDIS_MASK_RST      4'h0
`define GDIS_MODE_RST      3'h0
`define GDIS_LOCK_ALL      3'h7
// Idle levels of the synchronised pins {release, enables, fault, low, high_n}.
`define GDIS_SYNC_RST      10'h007
// Timing: the clock period and the least time out of standby.
`define GDIS_CLK_NS        100
`define GDIS_T_WAKE_NS     280
`define GDIS_WAKE_CYC      ((`GDIS_T_WAKE_NS + `GDIS_CLK_NS - 1) / `GDIS_CLK_NS)
`endif

// ==== logic/gdis_pkg.sv ====
// Types shared by the gate drive init sequencer.
// Assumes the constants header sits beside it.
package gdis_pkg;
  `include "gdis_cfg.svh"

  // Operating state of the output stage.
  typedef enum logic [1:0] {
    GDIS_STANDBY = 2'b00,
    GDIS_WAKE    = 2'b01,
    GDIS_NORMAL  = 2'b10
  } gdis_state_t;

  // Phase command pins after synchronisation.
  typedef struct packed {
    logic [2:0] low_side_cmd_in;
    logic [2:0] high_side_cmd_n_in;
  } gdis_cmd_t;

  // Gate drive outputs.
  typedef struct packed {
    logic [2:0] low_gate;
    logic [2:0] high_gate_out;
  } gdis_gate_t;
endpackage

// ==== tb/gdis_host_model.sv ====
// Host model: drives the release, enable and phase command pins.
// Assumes the bench calls its tasks in recovery order.
`timescale 1ns/10ps
module gdis_host_model
  import gdis_pkg::*;
(
  // Clock.
  input  wire logic i_clk,
  // Pins toward the device.
  output logic      o_release_n,
  output logic      o_enable_one,
  output logic      o_enable_two,
  output gdis_cmd_t o_cmd
);
  // ------
  // Pin tasks
  // ------
  // Device held in reset with every gate commanded off.
  initial begin
    o_release_n  = 1'b0;
    o_enable_one = 1'b0;
    o_enable_two = 1'b0;
    o_cmd        = 6'h07;
  end

  // Release the device while both enables are still low.
  task automatic release_dev();
    @(posedge i_clk);
    o_release_n <= 1'b1;
  endtask

  // Raising the enables waits out standby exit, plus margin for pin sync.
  task automatic set_enables(input logic on);
    @(posedge i_clk);
    o_enable_one <= on;
    o_enable_two <= on;
    repeat (8) @(posedge i_clk);
  endtask

  // One cycle is the short pulse allowed after standby or a fault.
  task automatic ls_pulse(input int n);
    @(posedge i_clk);
    o_cmd.low_side_cmd_in <= 3'h7;
    repeat (n) @(posedge i_clk);
    o_cmd.low_side_cmd_in <= 3'h0;
  endtask

  // All phases together, so the motor only recirculates.
  task automatic hs_pulse(input int n);
    @(posedge i_clk);
    o_cmd.high_side_cmd_n_in <= 3'h0;
    repeat (n) @(posedge i_clk);
    o_cmd.high_side_cmd_n_in <= 3'h7;
  endtask

  // Phase inputs tied: low side and high side move to one level at once.
  task automatic joint_level(input logic lvl);
    @(posedge i_clk);
    o_cmd <= {{3{lvl}}, {3{lvl}}};
  endtask
endmodule

// ==== tb/gate_drive_init_sequencer_tb.sv ====
// Bench for the gate drive init sequencer: commands, lockout, recovery.
// Assumes the host model beside it drives enables and phase pins.
`timescale 1ns/10ps
module gate_drive_init_sequencer_tb
  import gdis_pkg::*;
;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [3:0]  i_address;
  logic        i_read;
  logic        i_write;
  logic [31:0] i_writedata;
  logic        i_fault;
  logic        probe_r;
  logic        i_release_n;
  logic        i_enable_one;
  logic        i_enable_two;
  gdis_cmd_t   i_cmd;
  logic [31:0] o_readdata;
  logic        o_waitrequest;
  gdis_gate_t  o_gate;
  logic        o_pump_en;
  logic        o_irq_req;
  logic [31:0] exp_rd[$];
  logic [7:0]  exp_pin[$];
  logic [31:0] got_rd;
  logic [7:0]  got_pin;
  logic [3:0]  m;
  logic [3:0]  op;
  int          miscompares = 0;
  int          checks_done = 0;

  // A 100 ns clock.
  always #50 i_clk = ~i_clk;

  gdis_host_model i_host (.i_clk(i_clk), .o_release_n(i_release_n),
    .o_enable_one(i_enable_one), .o_enable_two(i_enable_two), .o_cmd(i_cmd));

  gdis_core i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_release_n(i_release_n), .i_enable_one(i_enable_one),
    .i_enable_two(i_enable_two), .i_cmd(i_cmd), .i_fault(i_fault), .o_gate(o_gate),
    .o_pump_en(o_pump_en), .o_irq_req(o_irq_req));

  // ------
  // Result monitor
  // ------
  // Each accepted read or pin probe takes the oldest noted expectation.
  always @(posedge i_clk) begin
    if (i_read === 1'b1 && o_waitrequest === 1'b0) begin
      got_rd = exp_rd.pop_front();
      checks_done++;
      if (o_readdata !== got_rd) begin
        miscompares++;
        $display("unexpected at %0t: read %h not %h", $time, o_readdata, got_rd);
      end
    end
    if (probe_r) begin
      got_pin = exp_pin.pop_front();
      checks_done++;
      if ({o_irq_req, o_pump_en, o_gate} !== got_pin) begin
        miscompares++;
        $display("unexpected at %0t: pins %h not %h", $time, {o_irq_req, o_pump_en, o_gate},
          got_pin);
      end
    end
  end

  // ------
  // Bus and probe tasks
  // ------
  task automatic print_verdict();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The request stands until waitrequest is sampled low; the wait is bounded.
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_read <= rd;
    i_write <= !rd;
    i_address <= a;
    i_writedata <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 20);
    if (n < 20) begin
      i_read <= 1'b0;
      i_write <= 1'b0;
    end else begin
      miscompares++;
      $display("unexpected at %0t: bus hang", $time);
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] b);
    bus(1'b0, 4'h0, {24'h0, b});
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b1, a, 32'h0);
  endtask

  // The answer to a command shows on the next transfer.
  task automatic cmd(input logic [7:0] b, input logic [31:0] e);
    wr(b);
    rd(4'h4, e);
  endtask

  // Pin vector is {irq, pump, low gates, high gates}.
  task automatic probe(input logic [7:0] e, input int k);
    repeat (k) @(posedge i_clk);
    exp_pin.push_back(e);
    probe_r <= 1'b1;
    @(posedge i_clk);
    probe_r <= 1'b0;
  endtask

  // ------
  // Scenarios
  // ------
  initial begin
    i_address   <= 4'h0;
    i_read      <= 1'b0;
    i_write     <= 1'b0;
    i_writedata <= 32'h0;
    i_fault     <= 1'b0;
    probe_r     <= 1'b0;
    void'($urandom(32'hae0a3e7b));
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    i_host.release_dev();
    wr(8'h60);
    wr(8'h70);
    cmd(8'h00, 32'h70);
    rd(4'hc, 32'h0);
    m = 4'($urandom);
    op = 4'h2 + 4'($urandom % 2);
    wr({op, m});
    cmd(8'h10, {24'h0, 4'h0, m});
    wr(8'h43);
    probe(8'h40, 4);
    wr(8'h40);
    cmd(8'h10, {24'h0, 4'h9, m});
    cmd(8'h00, 32'h78);
    wr(8'h28);
    probe(8'h40, 4);
    wr(8'h30);
    probe(8'hc0, 4);
    wr(8'h70);
    wr(8'h80);
    rd(4'h8, 32'h70);
    i_host.set_enables(1'b1);
    // A high-side edge in normal mode before the low-side pulse stays locked.
    i_host.hs_pulse(4);
    probe(8'hc0, 6);
    cmd(8'h00, 32'h74);
    wr(8'h70);
    // Full recovery after power-up.
    fork
      i_host.ls_pulse(10);
      probe(8'h78, 6);
    join
    rd(4'h8, 32'h800);
    fork
      i_host.hs_pulse(8);
      probe(8'h47, 6);
    join
    probe(8'h40, 4);
    // A fault while a gate is on forces all low and locks again.
    fork
      i_host.ls_pulse(16);
      begin
        probe(8'h78, 6);
        i_fault <= 1'b1;
        probe(8'hc0, 6);
      end
    join
    i_fault <= 1'b0;
    cmd(8'h00, 32'h73);
    wr(8'h60);
    repeat (10) @(posedge i_clk);
    i_host.ls_pulse(1);
    repeat (3) @(posedge i_clk);
    fork
      i_host.hs_pulse(8);
      probe(8'h47, 6);
    join
    rd(4'h8, 32'h800);
    // Phase inputs tied: one level moves low side and high side together.
    i_host.joint_level(1'b1);
    probe(8'h78, 4);
    i_host.joint_level(1'b0);
    probe(8'h47, 4);
    i_host.joint_level(1'b1);
    probe(8'h78, 4);
    // Dropping the enables is standby: gates low and locks set.
    i_host.set_enables(1'b0);
    probe(8'hc0, 2);
    rd(4'h8, 32'h72);
    print_verdict();
  end
endmodule
